// File: hw/flash_ctl_regs.svh
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH

// Byte addresses on the register bus
`define ADDR_MAIN_FLASH_SIZE 12'h000
`define ADDR_BOOT_FLASH_SIZE 12'h004
`define ADDR_FLASH_CONTROL 12'h008
`define ADDR_UNLOCK_KEY 12'h00C

// Control register field positions
`define CTRL_START_BIT 15
`define CTRL_PERMIT_BIT 14
`define CTRL_FAILED_BIT 13
`define CTRL_UV_FAULT_BIT 12
`define CTRL_UV_ACTIVE_BIT 11
`define CTRL_OPSEL_MSB 3
`define CTRL_OPSEL_LSB 0

// Reset values
`define CTRL_RESET_VALUE 32'h0000_0000
`define OPSEL_RESET_VALUE 4'h0

// Legal main flash sizes in bytes
`define MAIN_FLASH_SIZE_16K 32'h0000_4000
`define MAIN_FLASH_SIZE_32K 32'h0000_8000
`define MAIN_FLASH_SIZE_64K 32'h0001_0000
`define MAIN_FLASH_SIZE_128K 32'h0002_0000
`define MAIN_FLASH_SIZE_256K 32'h0004_0000

// Boot region is fixed at 3 KB
`define BOOT_FLASH_SIZE_VALUE 32'h0000_0C00

// Unlock keys, arbitrary values
`define UNLOCK_KEY_FIRST_VALUE 32'h5A5A_1234
`define UNLOCK_KEY_SECOND_VALUE 32'hA5A5_8765

// Cycles that the launch pulse to the flash macro stays high
`define FLASH_GO_CYCLES 1

`endif

// File: hw/flash_ctl_pkg.sv
package flash_ctl_pkg;

  typedef enum logic [3:0] {
    OP_NOP_0 = 4'h0,
    OP_WORD_PROGRAM = 4'h1,
    OP_NOP_2 = 4'h2,
    OP_ROW_PROGRAM = 4'h3,
    OP_PAGE_ERASE = 4'h4,
    OP_MAIN_ERASE = 4'h5,
    OP_NOP_6 = 4'h6
  } operation_select_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ISSUE = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } engine_state_t;

  typedef enum logic [3:0] {
    SEL_NONE = 4'b0000,
    SEL_MAIN_SIZE = 4'b0001,
    SEL_BOOT_SIZE = 4'b0010,
    SEL_CONTROL = 4'b0100,
    SEL_KEY = 4'b1000
  } reg_select_t;

endpackage

// File: hw/flash_op_if.sv
interface flash_op_if;
  logic launch;
  logic [3:0] code;
  logic uv_seen;
  logic busy;
  logic finished;
  logic failed;

  modport ctrl (
    output launch,
    output code,
    output uv_seen,
    input busy,
    input finished,
    input failed
  );

  modport engine (
    input launch,
    input code,
    input uv_seen,
    output busy,
    output finished,
    output failed
  );
endinterface

// File: hw/flash_op_engine.sv
`include "flash_ctl_regs.svh"

module flash_op_engine (
  input wire logic ref_clk,
  input wire logic rst,
  flash_op_if.engine op,
  output logic flash_go,
  output logic [3:0] flash_cmd,
  input wire logic flash_done_s,
  input wire logic flash_error_s
);

  flash_ctl_pkg::engine_state_t state_q;
  flash_ctl_pkg::engine_state_t state_d;
  logic failed_q;
  logic uv_hit_q;
  logic [3:0] cmd_q;

  // Codes that reach the flash macro; all others finish at once
  function automatic logic is_real_op(input logic [3:0] code);
    is_real_op = (code == flash_ctl_pkg::OP_WORD_PROGRAM) ||
                 (code == flash_ctl_pkg::OP_ROW_PROGRAM) ||
                 (code == flash_ctl_pkg::OP_PAGE_ERASE) ||
                 (code == flash_ctl_pkg::OP_MAIN_ERASE);
  endfunction

  wire real_op = is_real_op(op.code);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      flash_ctl_pkg::ST_IDLE: begin
        if (op.launch) begin
          state_d = real_op ? flash_ctl_pkg::ST_ISSUE : flash_ctl_pkg::ST_DONE;
        end
      end
      flash_ctl_pkg::ST_ISSUE: state_d = flash_ctl_pkg::ST_WAIT;
      flash_ctl_pkg::ST_WAIT: begin
        if (flash_done_s) begin
          state_d = flash_ctl_pkg::ST_DONE;
        end
      end
      flash_ctl_pkg::ST_DONE: state_d = flash_ctl_pkg::ST_IDLE;
      default: state_d = flash_ctl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= flash_ctl_pkg::ST_IDLE;
      cmd_q <= `OPSEL_RESET_VALUE;
    end else begin
      state_q <= state_d;
      if (op.launch) begin
        cmd_q <= op.code;
      end
    end
  end

  // Low voltage while a real operation is in ST_WAIT counts as a failed operation
  always_ff @(posedge ref_clk) begin
    if (rst || op.launch) begin
      uv_hit_q <= 1'b0;
      failed_q <= 1'b0;
    end else if (state_q == flash_ctl_pkg::ST_WAIT) begin
      uv_hit_q <= uv_hit_q | op.uv_seen;
      if (flash_done_s) begin
        failed_q <= flash_error_s | uv_hit_q | op.uv_seen;
      end
    end
  end

  assign flash_go = (state_q == flash_ctl_pkg::ST_ISSUE);
  assign flash_cmd = cmd_q;
  assign op.busy = (state_q != flash_ctl_pkg::ST_IDLE);
  assign op.finished = (state_q == flash_ctl_pkg::ST_DONE);
  assign op.failed = (state_q == flash_ctl_pkg::ST_DONE) && failed_q;

endmodule

// File: hw/flash_size_ctrl.sv
// Function
// - Read-only word reporting main flash bytes
// - Main size is one of five legal values
// - Second read-only word reporting boot size
// - Boot size always reads 0x00000C00
// - Control register field layout and reset zero
// - Start needs permit and unlock; self-clears
// - Permit gates start, enables detector, resets
// - Hardware flags set; failed and UV fault cleared by launching 0000
// - Operation select writable only without permit
`include "flash_ctl_regs.svh"

module flash_size_ctrl #(
  parameter logic [31:0] MAIN_FLASH_BYTES = `MAIN_FLASH_SIZE_256K,
  parameter logic [31:0] UNLOCK_KEY_FIRST = `UNLOCK_KEY_FIRST_VALUE,
  parameter logic [31:0] UNLOCK_KEY_SECOND = `UNLOCK_KEY_SECOND_VALUE
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic device_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flash_go,
  output logic [3:0] flash_cmd,
  input wire logic flash_done,
  input wire logic flash_error,
  input wire logic undervoltage_in,
  output logic undervoltage_detector_en
);

  localparam int SYNC_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  wire [SYNC_W-1:0] pins_raw = {undervoltage_in, flash_error, flash_done};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pins_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire flash_done_s = sync2_q[0];
  wire flash_error_s = sync2_q[1];
  wire undervoltage_s = sync2_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Size constants

  function automatic logic legal_main_size(input logic [31:0] bytes);
    legal_main_size = (bytes == `MAIN_FLASH_SIZE_16K) ||
                      (bytes == `MAIN_FLASH_SIZE_32K) ||
                      (bytes == `MAIN_FLASH_SIZE_64K) ||
                      (bytes == `MAIN_FLASH_SIZE_128K) ||
                      (bytes == `MAIN_FLASH_SIZE_256K);
  endfunction

  // An illegal parameter falls back to the largest part
  wire [31:0] main_flash_size_value = legal_main_size(MAIN_FLASH_BYTES) ?
                                      MAIN_FLASH_BYTES : `MAIN_FLASH_SIZE_256K;
  wire [31:0] boot_region_size_value = `BOOT_FLASH_SIZE_VALUE;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  function automatic flash_ctl_pkg::reg_select_t decode(input logic [11:0] addr);
    case (addr)
      `ADDR_MAIN_FLASH_SIZE: decode = flash_ctl_pkg::SEL_MAIN_SIZE;
      `ADDR_BOOT_FLASH_SIZE: decode = flash_ctl_pkg::SEL_BOOT_SIZE;
      `ADDR_FLASH_CONTROL: decode = flash_ctl_pkg::SEL_CONTROL;
      `ADDR_UNLOCK_KEY: decode = flash_ctl_pkg::SEL_KEY;
      default: decode = flash_ctl_pkg::SEL_NONE;
    endcase
  endfunction

  wire flash_ctl_pkg::reg_select_t sel = decode(paddr);
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire addr_ok = (sel != flash_ctl_pkg::SEL_NONE);
  wire wr_ok = access_phase & pwrite & addr_ok;
  // Size words ignore writes; no error so a blind write-back is harmless
  wire ctrl_wr = wr_ok & (sel == flash_ctl_pkg::SEL_CONTROL);
  wire key_wr = wr_ok & (sel == flash_ctl_pkg::SEL_KEY);
  wire lane1_wr = ctrl_wr & pstrb[1];
  wire lane0_wr = ctrl_wr & pstrb[0];

  ////////////////////////////////////////////////////////////////////////////
  // Unlock sequence

  logic key_armed_q;
  logic unlocked_q;
  wire full_key_wr = key_wr & (pstrb == 4'hF);
  wire key_first_ok = full_key_wr & (pwdata == UNLOCK_KEY_FIRST);
  wire key_second_ok = full_key_wr & (pwdata == UNLOCK_KEY_SECOND) & key_armed_q;
  // Any other write to a mapped address breaks the sequence, as does its use by a control write
  wire other_wr = wr_ok & ~key_wr;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      key_armed_q <= 1'b0;
      unlocked_q <= 1'b0;
    end else begin
      if (key_wr) begin
        key_armed_q <= key_first_ok;
        unlocked_q <= key_second_ok;
      end else if (other_wr) begin
        key_armed_q <= 1'b0;
        unlocked_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  flash_op_if op ();

  logic start_q;
  logic launch_permit_q;
  logic operation_failed_flag_q;
  logic undervoltage_fault_flag_q;
  logic undervoltage_active_flag_q;
  logic [3:0] operation_select_q;
  logic launch_q;

  wire start_req = lane1_wr & pwdata[`CTRL_START_BIT];
  wire launch_ok = start_req & launch_permit_q & unlocked_q & ~start_q & ~op.busy;
  wire clear_flags = launch_q & (operation_select_q == flash_ctl_pkg::OP_NOP_0);
  wire uv_detect = undervoltage_s & launch_permit_q;

  logic start_d;
  logic permit_d;
  logic [3:0] opsel_d;

  always_comb begin
    start_d = start_q;
    if (launch_ok) begin
      start_d = 1'b1;
    end else if (op.finished) begin
      start_d = 1'b0;
    end
  end

  always_comb begin
    permit_d = launch_permit_q;
    if (device_reset) begin
      permit_d = 1'b0;
    end else if (lane1_wr) begin
      permit_d = pwdata[`CTRL_PERMIT_BIT];
    end
  end

  always_comb begin
    opsel_d = operation_select_q;
    if (lane0_wr && !launch_permit_q) begin
      opsel_d = pwdata[`CTRL_OPSEL_MSB:`CTRL_OPSEL_LSB];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_d;
    end
  end

  // Power-on reset, device reset or a control write with bit 14 clear may clear the permit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      launch_permit_q <= 1'b0;
    end else begin
      launch_permit_q <= permit_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      operation_select_q <= `OPSEL_RESET_VALUE;
    end else begin
      operation_select_q <= opsel_d;
    end
  end

  // One cycle late so the engine sees a settled code
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      launch_q <= 1'b0;
    end else begin
      launch_q <= launch_ok;
    end
  end

  // Set wins over the clear of a zero-code launch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      operation_failed_flag_q <= 1'b0;
    end else if (op.failed) begin
      operation_failed_flag_q <= 1'b1;
    end else if (clear_flags) begin
      operation_failed_flag_q <= 1'b0;
    end
  end

  // Sticky until software clears it, even after the pin recovers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      undervoltage_fault_flag_q <= 1'b0;
    end else if (uv_detect) begin
      undervoltage_fault_flag_q <= 1'b1;
    end else if (clear_flags) begin
      undervoltage_fault_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      undervoltage_active_flag_q <= 1'b0;
    end else begin
      undervoltage_active_flag_q <= uv_detect;
    end
  end

  assign op.launch = launch_q;
  assign op.code = operation_select_q;
  assign op.uv_seen = uv_detect;
  assign undervoltage_detector_en = launch_permit_q;

  flash_op_engine u_engine (
    .ref_clk(ref_clk),
    .rst(rst),
    .op(op),
    .flash_go(flash_go),
    .flash_cmd(flash_cmd),
    .flash_done_s(flash_done_s),
    .flash_error_s(flash_error_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Flags only come from hardware; bits 10:4 and 31:16 stay zero
  wire [31:0] ctrl_read = {
    16'h0000,
    start_q,
    launch_permit_q,
    operation_failed_flag_q,
    undervoltage_fault_flag_q,
    undervoltage_active_flag_q,
    7'h00,
    operation_select_q
  };

  logic [31:0] read_mux;

  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (sel)
      flash_ctl_pkg::SEL_MAIN_SIZE: read_mux = main_flash_size_value;
      flash_ctl_pkg::SEL_BOOT_SIZE: read_mux = boot_region_size_value;
      flash_ctl_pkg::SEL_CONTROL: read_mux = ctrl_read;
      flash_ctl_pkg::SEL_KEY: read_mux = 32'h0000_0000;
      flash_ctl_pkg::SEL_NONE: read_mux = 32'h0000_0000;
    endcase
  end

  // Data and error are caught in the setup cycle so they come from flops
  logic [31:0] prdata_q;
  logic pslverr_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q <= pwrite ? 32'h0000_0000 : read_mux;
      pslverr_q <= ~addr_ok;
    end
  end

  assign prdata = prdata_q;
  assign pready = access_phase;
  assign pslverr = pslverr_q & access_phase;

endmodule

// File: sim/flash_size_ctrl_sva.sv
module flash_size_ctrl_sva #(
  parameter logic [31:0] MAIN_FLASH_BYTES = 32'h0004_0000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic device_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flash_go,
  input wire logic [3:0] flash_cmd,
  input wire logic flash_done,
  input wire logic flash_error,
  input wire logic undervoltage_in,
  input wire logic undervoltage_detector_en
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  wire logic rd_acc = psel && penable && !pwrite;
  wire logic go_wr = psel && penable && pwrite && paddr == 12'h008 && pwdata[15] && pstrb[1];
  sequence s_go_pulse;
    flash_go ##1 !flash_go;
  endsequence
  // Detector off long enough for the synchroniser to drain
  sequence s_permit_off;
    !undervoltage_detector_en [*5];
  endsequence
  ////////////////////////////////////////
  AST_MAIN_SIZE:
    assert property (rd_acc && paddr == 12'h000 |-> prdata == MAIN_FLASH_BYTES)
    else $error("main size read wrong");
  AST_BOOT_SIZE:
    assert property (rd_acc && paddr == 12'h004 |-> prdata == 32'h0000_0C00)
    else $error("boot size read wrong");
  AST_CTRL_UNUSED:
    assert property (rd_acc && paddr == 12'h008 |-> prdata[31:16] == 16'h0 && prdata[10:4] == 7'h0)
    else $error("unused control bits not zero");
  AST_GO_CAUSE:
    assert property ($rose(flash_go) |-> $past(go_wr, 2) || $past(go_wr, 3) || $past(go_wr, 4))
    else $error("launch without start write");
  AST_GO_PULSE:
    assert property ($rose(flash_go) |-> s_go_pulse)
    else $error("launch pulse too long");
  AST_GO_CODE:
    assert property (flash_go |-> flash_cmd inside {4'h1, 4'h3, 4'h4, 4'h5})
    else $error("launch with no-op code");
  AST_DEV_RESET:
    assert property (device_reset |-> ##2 !undervoltage_detector_en)
    else $error("detector kept on after device reset");
  AST_UV_IDLE:
    assert property (s_permit_off ##0 (rd_acc && paddr == 12'h008) |-> !prdata[11])
    else $error("undervoltage status with detector off");
  AST_RST:
    assert property (disable iff (1'b0) rst |=> !flash_go && flash_cmd == 4'h0 && !pslverr
      && !undervoltage_detector_en)
    else $error("outputs not cleared by reset");
endmodule

bind flash_size_ctrl flash_size_ctrl_sva #(.MAIN_FLASH_BYTES(MAIN_FLASH_BYTES)) i_sva (
  .ref_clk(ref_clk), .rst(rst), .device_reset(device_reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .flash_go(flash_go), .flash_cmd(flash_cmd),
  .flash_done(flash_done), .flash_error(flash_error), .undervoltage_in(undervoltage_in),
  .undervoltage_detector_en(undervoltage_detector_en));

// File: sim/flash_size_ctrl_tb.sv
`include "flash_ctl_regs.svh"

module flash_size_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MAIN_BYTES = 32'h0002_0000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic device_reset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic flash_go;
  logic [3:0] flash_cmd;
  logic flash_done = 1'b0;
  logic flash_error = 1'b0;
  logic undervoltage_in = 1'b0;
  logic undervoltage_detector_en;
  logic [31:0] rdat;
  logic rerr;
  int n_errors = 0;
  int cmp_count = 0;
  int go_seen = 0;
  int permit = 0;
  int opsel = 0;
  int failed = 0;
  int fault = 0;
  int uvact = 0;
  logic [3:0] codes [9] = '{4'h1, 4'h5, 4'h3, 4'h4, 4'h0, 4'h2, 4'h6, 4'h7, 4'hF};

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (flash_go === 1'b1) go_seen++;

  flash_size_ctrl #(.MAIN_FLASH_BYTES(MAIN_BYTES)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .device_reset(device_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_go(flash_go), .flash_cmd(flash_cmd),
    .flash_done(flash_done), .flash_error(flash_error), .undervoltage_in(undervoltage_in),
    .undervoltage_detector_en(undervoltage_detector_en));

  ////////////////////////////////////////
  task automatic close_out;
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_errors++;
      close_out();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, rdat, exp);
  endtask

  function automatic logic [31:0] ctrl_exp();
    return {16'h0, 1'b0, permit[0], failed[0], fault[0], uvact[0], 7'h0, opsel[3:0]};
  endfunction

  // Opsel only follows while the old permit is clear
  task automatic wctl(input logic [31:0] w);
    apb(1'b1, 12'h008, w);
    if (permit == 0) opsel = w[3:0];
    permit = w[14];
  endtask

  task automatic run_op(input logic [3:0] c, input logic err);
    int n;
    logic real_op;
    real_op = c inside {4'h1, 4'h3, 4'h4, 4'h5};
    wctl({28'h0, c});
    wctl({16'h0, 4'h4, 8'h0, c});
    apb(1'b1, 12'h00C, `UNLOCK_KEY_FIRST_VALUE);
    apb(1'b1, 12'h00C, `UNLOCK_KEY_SECOND_VALUE);
    n = go_seen;
    apb(1'b1, 12'h008, {16'h0, 4'hC, 8'h0, c});
    if (real_op) begin
      for (int k = 0; k < 20 && flash_go !== 1'b1; k++) @(posedge ref_clk);
      if (flash_go !== 1'b1) begin
        n_errors++;
        close_out();
      end
      chk("command", {28'h0, flash_cmd}, {28'h0, c});
      flash_done <= 1'b1;
      flash_error <= err;
      repeat (2) @(posedge ref_clk);
      flash_done <= 1'b0;
      flash_error <= 1'b0;
      if (err) failed = 1;
    end
    if (c == 4'h0) begin
      failed = 0;
      fault = 0;
    end
    // Bounded poll; a stuck start bit shows up in the compare
    for (int k = 0; k < 30; k++) begin
      apb(1'b0, 12'h008, 32'h0);
      if (rdat[15] === 1'b0) break;
    end
    chk("after op", rdat, ctrl_exp());
    chk("launches", go_seen - n, {31'h0, real_op});
  endtask

  initial begin
    void'($urandom(32'h2686));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd(12'h000, MAIN_BYTES, "main size");
    rd(12'h004, 32'h0000_0C00, "boot size");
    rd(12'h008, 32'h0, "control reset");
    apb(1'b1, 12'h000, $urandom());
    apb(1'b1, 12'h004, $urandom());
    rd(12'h000, MAIN_BYTES, "main size kept");
    rd(12'h004, 32'h0000_0C00, "boot size kept");
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", {31'h0, rerr}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      wctl($urandom());
      rd(12'h008, ctrl_exp(), "control random");
      chk("detector", {31'h0, undervoltage_detector_en}, {31'h0, permit[0]});
    end
    wctl({16'h0, 4'h4, 8'h0, opsel[3:0]});
    wctl({16'h0, 4'hC, 8'h0, opsel[3:0]});
    rd(12'h008, ctrl_exp(), "start locked");
    undervoltage_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    uvact = 1;
    fault = 1;
    rd(12'h008, ctrl_exp(), "undervoltage on");
    undervoltage_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    uvact = 0;
    rd(12'h008, ctrl_exp(), "undervoltage off");
    device_reset <= 1'b1;
    @(posedge ref_clk);
    device_reset <= 1'b0;
    permit = 0;
    rd(12'h008, ctrl_exp(), "device reset");
    chk("detector off", {31'h0, undervoltage_detector_en}, 32'h0);
    undervoltage_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(12'h008, ctrl_exp(), "undervoltage gated");
    undervoltage_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) run_op(codes[i], i == 1);
    close_out();
  end
endmodule
